/* File: verification/bcd_reading_out_tb.sv */
// self-checking bench for the parallel bcd reading output
module bcd_reading_out_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bcd_out_pkg::*;
   logic ref_clk, nrst, pos, over, refresh, hold, neg, rel, rv, rv_d, rl;
   logic [DATA_W-1:0] bcd, d, doe;
   logic v, voe, s, soe, o, ooe;
   logic [22:0] rw, last, held, cur;
   logic [22:0] q[$];
   int error_cnt, cmp_count, cyc, r;
   bcd_reading_out #(.VALID_CYCLES(5)) dut (.ref_clk(ref_clk), .nrst(nrst),
      .reading_bcd(bcd), .reading_pos(pos), .reading_over(over),
      .refresh(refresh), .hold(hold), .neg_sense(neg), .release_bus(rel),
      .data_o(d), .data_oe_n(doe), .valid_o(v), .valid_oe_n(voe),
      .sign_o(s), .sign_oe_n(soe), .over_o(o), .over_oe_n(ooe));
   bus_reader rdr (.data_o(d), .data_oe_n(doe), .valid_o(v), .valid_oe_n(voe),
      .sign_o(s), .sign_oe_n(soe), .over_o(o), .over_oe_n(ooe),
      .neg_sense(neg), .rd_word(rw), .rd_valid(rv), .released(rl));
   task automatic cmp_word(logic [22:0] e, logic [22:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %0t word %h exp %h", $time, g, e);
      end
   endtask : cmp_word
   task automatic cmp_bit(logic e, logic g);
      cmp_word({22'h0, e}, {22'h0, g});
   endtask : cmp_bit
   task automatic summarize;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   // one reading; over forces the low digits to ones
   task automatic send(logic p, logic ov, int gap);
      logic [DATA_W-1:0] b;
      for (int k = 0; k < 5; k++) b[4*k+:4] = 4'($urandom % 10);
      b[20] = 1'($urandom % 2);
      @(posedge ref_clk);
      {bcd, pos, over, refresh} <= {b, p, ov, 1'b1};
      last = {ov ? {b[20:16], 16'hFFFF} : b, p, ov};
      if (!hold) q.push_back(last);
      @(posedge ref_clk);
      refresh <= 1'b0;
      repeat (gap) @(posedge ref_clk);
   endtask : send
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // monitor pops a note on each new valid
   always @(posedge ref_clk) begin
      rv_d <= rv;
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         error_cnt++;
         summarize();
      end else if (rv && !rl) begin
         if (!rv_d && q.size() == 0) cmp_bit(1'b0, 1'b1);
         else if (!rv_d) begin
            cur = q.pop_front();
            cmp_word(cur, rw);
         end else cmp_word(cur, rw);
      end
   end
   initial begin
      {nrst, pos, over, refresh, hold, neg, rel, bcd} = '0;
      r = $urandom(30874);
      for (int n = 0; n < 2; n++) begin
         nrst <= 1'b0;
         neg <= n[0];
         repeat (16) @(posedge ref_clk);
         nrst <= 1'b1;
         // the third reading arrives during a valid pulse and waits
         for (int i = 0; i < 4; i++) begin
            send(i[0], i[1], (i == 1) ? 2 : 9);
         end
         held = last;
         hold <= 1'b1;
         send(1'b1, 1'b0, 9);
         cmp_word(held, rw);
         hold <= 1'b0;
         rel <= 1'b1;
         repeat (3) @(posedge ref_clk);
         cmp_bit(1'b1, rl);
         rel <= 1'b0;
         repeat (3) @(posedge ref_clk);
         cmp_bit(1'b0, rl);
         send(1'b0, 1'b1, 9);
      end
      cmp_bit(1'b0, q.size() != 0);
      summarize();
   end
endmodule : bcd_reading_out_tb

/* File: verification/bus_reader.sv */
// reader model on the shared bus, pull-ups on every line
module bus_reader (
   input wire logic [20:0] data_o,
   input wire logic [20:0] data_oe_n,
   input wire logic valid_o,
   input wire logic valid_oe_n,
   input wire logic sign_o,
   input wire logic sign_oe_n,
   input wire logic over_o,
   input wire logic over_oe_n,
   input wire logic neg_sense,
   output logic [22:0] rd_word,
   output logic rd_valid,
   output logic released
);
   logic [23:0] oe_n;
   logic [23:0] lvl;
   assign oe_n = {data_oe_n, valid_oe_n, sign_oe_n, over_oe_n};
   assign lvl = ({data_o, valid_o, sign_o, over_o} | oe_n) ^ {24{neg_sense}};
   assign rd_word = {lvl[23:3], lvl[1:0]};
   assign rd_valid = lvl[2];
   assign released = &oe_n;
endmodule : bus_reader

/* File: verilog/bcd_out_pkg.sv */
// shared constants for the parallel bcd reading output
package bcd_out_pkg;
   // =====================================================
   // widths
   localparam int DATA_W = 21;
   localparam int NIB_W = 4;
   localparam int LOW_DIGITS = 4;
   // =====================================================
   // timing
   localparam int CLK_MHZ = 100;
   localparam int VALID_MS = 62;
   localparam int VALID_CYC = VALID_MS * 1000 * CLK_MHZ;
   // =====================================================
   // reset values, ones nibble and phase type
   localparam logic [DATA_W-1:0] DATA_RST = 21'h00_0000;
   localparam logic [NIB_W-1:0] NIB_ONES = 4'hF;
   localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_VALID} phase_e;
endpackage : bcd_out_pkg

/* File: verilog/bcd_pin_sense.sv */
// applies the logic sense and release to one group of output pins
module bcd_pin_sense #(
   parameter int W = 24
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [W-1:0] active,
   input wire logic neg_sense,
   input wire logic release_bus,
   output logic [W-1:0] pin_o,
   output logic [W-1:0] pin_oe_n
);
   typedef struct packed {
      logic [W-1:0] pin;
      logic [W-1:0] oe_n;
   } pins_s;
   pins_s st_r;
   pins_s st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.pin = neg_sense ? ~active : active;
      st_nxt.oe_n = release_bus ? {W{1'b1}} : {W{1'b0}};
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '{pin: '0, oe_n: '1};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign pin_o = st_r.pin;
   assign pin_oe_n = st_r.oe_n;
endmodule : bcd_pin_sense

/* File: verilog/bcd_reading_out.sv */
// parallel bcd reading output port of the panel meter
// How it works
// - reading as 8421 bcd on 21 lines
// - release input floats all outputs
// - refresh data on each display refresh
// - data valid pulses per new reading
// - hold freezes outputs at last reading
// - sense input sets all output polarity
// - positive high active, negative low active
// - release input always active high
// - sign high when reading positive
// - overrange high when out of range
// - overrange forces low four digits ones
module bcd_reading_out
   import bcd_out_pkg::*;
#(
   parameter int VALID_CYCLES = bcd_out_pkg::VALID_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [bcd_out_pkg::DATA_W-1:0] reading_bcd,
   input wire logic reading_pos,
   input wire logic reading_over,
   input wire logic refresh,
   input wire logic hold,
   input wire logic neg_sense,
   input wire logic release_bus,
   output logic [bcd_out_pkg::DATA_W-1:0] data_o,
   output logic [bcd_out_pkg::DATA_W-1:0] data_oe_n,
   output logic valid_o,
   output logic valid_oe_n,
   output logic sign_o,
   output logic sign_oe_n,
   output logic over_o,
   output logic over_oe_n
);
   import bcd_out_pkg::*;
   localparam int PW = DATA_W + 3;
   // =====================================================
   // state
   typedef struct packed {
      phase_e phase;
      logic [DATA_W-1:0] data;
      logic sign;
      logic over;
      logic valid;
      logic pend;
      // wide enough for the slowest valid width
      logic [31:0] cnt;
   } out_s;
   out_s st_r;
   out_s st_nxt;
   logic [DATA_W-1:0] shaped;
   logic [PW-1:0] pin_o;
   logic [PW-1:0] pin_oe_n;
   // =====================================================
   // overrange shaping
   // weighted nibbles pass through
   genvar g;
   generate
      for (g = 0; g < DATA_W; g++) begin : g_bit
         if (g < LOW_DIGITS * NIB_W) begin : g_low
            assign shaped[g] = reading_over | reading_bcd[g];
         end else begin : g_high
            assign shaped[g] = reading_bcd[g];
         end
      end
   endgenerate
   // =====================================================
   // sequencing
   always_comb begin
      st_nxt = st_r;
      if (refresh && !hold) begin
         st_nxt.pend = 1'b1;
      end
      case (st_r.phase)
         ST_IDLE: begin
            // a coalesced refresh loads the inputs standing now,
            // so the source must hold its reading until then
            if (st_nxt.pend && !hold) begin
               st_nxt.data = shaped;
               st_nxt.sign = reading_pos;
               st_nxt.over = reading_over;
               st_nxt.pend = 1'b0;
               st_nxt.phase = ST_LOAD;
            end
         end
         ST_LOAD: begin
            st_nxt.valid = 1'b1;
            st_nxt.cnt = CNT_ZERO;
            st_nxt.phase = ST_VALID;
         end
         ST_VALID: begin
            if (st_r.cnt >= 32'(VALID_CYCLES - 1)) begin
               st_nxt.valid = 1'b0;
               st_nxt.phase = ST_IDLE;
            end else begin
               st_nxt.cnt = st_r.cnt + 32'h0000_0001;
            end
         end
         default: begin
            st_nxt.phase = ST_IDLE;
            st_nxt.valid = 1'b0;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '{phase: ST_IDLE, data: DATA_RST, sign: 1'b0,
                   over: 1'b0, valid: 1'b0, pend: 1'b0, cnt: CNT_ZERO};
      end else begin
         st_r <= st_nxt;
      end
   end
   // =====================================================
   // pin stage; sense is static, jumper like
   // sense on all outputs, not release
   bcd_pin_sense #(.W(PW)) u_pins (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .active({st_r.over, st_r.sign, st_r.valid, st_r.data}),
      .neg_sense(neg_sense),
      .release_bus(release_bus),
      .pin_o(pin_o),
      .pin_oe_n(pin_oe_n)
   );
   assign data_o = pin_o[DATA_W-1:0];
   assign valid_o = pin_o[DATA_W];
   assign sign_o = pin_o[DATA_W+1];
   assign over_o = pin_o[DATA_W+2];
   assign data_oe_n = pin_oe_n[DATA_W-1:0];
   assign valid_oe_n = pin_oe_n[DATA_W];
   assign sign_oe_n = pin_oe_n[DATA_W+1];
   assign over_oe_n = pin_oe_n[DATA_W+2];
   // =====================================================
   // checks on internal state
   a_data_stable: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      st_r.valid |=> $stable(st_r.data))
      else $error("data changed while valid");
   a_over_ones: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      st_r.over |-> (st_r.data[15:0] == 16'hFFFF))
      else $error("overrange digits not ones");
   a_valid_follows: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (st_r.phase == ST_LOAD) |=> st_r.valid)
      else $error("valid missing after load");
   a_hold_freeze: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      hold |=> $stable(st_r.data))
      else $error("data changed during hold");
   a_refresh_load: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (refresh && !hold && st_r.phase == ST_IDLE) |=>
      (st_r.phase == ST_LOAD))
      else $error("refresh not loaded");
   a_sign_copy: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (st_nxt.phase == ST_LOAD && st_r.phase == ST_IDLE) |=>
      (st_r.sign == $past(reading_pos)))
      else $error("sign not captured");
   // refresh during hold is dropped, not queued
   a_hold_drop: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (hold && !st_r.pend) |=> !st_r.pend)
      else $error("refresh queued during hold");
   a_plain_load: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (st_r.phase == ST_IDLE && st_nxt.phase == ST_LOAD && !reading_over)
      |=> (st_r.data == $past(reading_bcd)))
      else $error("reading not passed through");
   a_over_copy: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (st_r.phase == ST_IDLE && st_nxt.phase == ST_LOAD)
      |=> (st_r.over == $past(reading_over)))
      else $error("overrange not captured");
   a_valid_end: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (st_r.phase == ST_VALID && st_r.cnt == 32'(VALID_CYCLES - 1))
      |=> !st_r.valid)
      else $error("valid longer than its width");
   a_load_quiet: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (st_r.phase == ST_LOAD) |-> !st_r.valid)
      else $error("data loaded while valid");
   // =====================================================
   // checks on pins
   // pins lag the state by one register; skip the reset edge
   a_release_float: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      release_bus |=> (&pin_oe_n))
      else $error("outputs driven during release");
   a_drive_low: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (nrst && !release_bus) |=> (pin_oe_n == '0))
      else $error("outputs floating without release");
   a_release_sense: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      nrst |=> (over_oe_n == $past(release_bus)))
      else $error("release level depends on sense");
   a_sense_pol: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      nrst |=> (valid_o == ($past(neg_sense) ^ $past(st_r.valid))))
      else $error("valid polarity wrong");
   a_data_pins: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      nrst |=> (data_o ==
         ($past(st_r.data) ^ {DATA_W{$past(neg_sense)}})))
      else $error("data pin level wrong");
   a_sign_pin: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      nrst |=> (sign_o == ($past(st_r.sign) ^ $past(neg_sense))))
      else $error("sign pin level wrong");
   a_over_pin: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      nrst |=> (over_o == ($past(st_r.over) ^ $past(neg_sense))))
      else $error("overrange pin level wrong");
endmodule : bcd_reading_out
